// [test/dtc_pin_model.sv]
/*
  outside world at the count pins and the external clock input.
  assumes start is a one-cycle request; count pins idle high (pull-up).
*/
`timescale 1ns/1ns
module dtc_pin_model (
  input  wire       clk,
  input  wire       start,
  input  wire       sel,
  input  wire [7:0] edges,
  output reg        pin0 = 1'b1,
  output reg        pin1 = 1'b1,
  output reg        ext_clock = 1'b0,
  output reg        busy = 1'b0
);
  reg [1:0] div = 2'b00;

////////////////////////////////////////////////////////////////////////
  // oscillator runs free, period of four system clocks
  always @(posedge clk) begin
    div       <= div + 2'b01;
    ext_clock <= div[1];
  end

  // three cycles per level, above the two-cycle minimum
  always @(posedge clk) begin
    if (start) begin
      busy <= 1'b1;
      repeat (edges) begin
        if (sel) pin1 <= 1'b0;
        else pin0 <= 1'b0;
        repeat (3) @(posedge clk);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        repeat (3) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule // dtc_pin_model

// [test/dtc_timer01_props.sv]
/*
  port checker for the dual timer block: clock select outputs, readback
  of config and flags, flag holding.
  assumes it is bound into dtc_timer01 and sees only its ports.
*/
`timescale 1ns/1ns
module dtc_timer01_props (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] sfr_addr,
  input wire       sfr_write,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire       timer0_irq_enable,
  input wire       timer1_irq_enable,
  input wire       timer0_vector_ack,
  input wire       timer1_vector_ack,
  input wire       timer0_irq,
  input wire       timer1_irq,
  input wire       timer3_high_clock_choice,
  input wire       timer3_low_clock_choice,
  input wire       timer2_high_clock_choice,
  input wire       timer2_low_clock_choice
);
  wire [3:0] ck_hi = {timer3_high_clock_choice, timer3_low_clock_choice,
                      timer2_high_clock_choice, timer2_low_clock_choice};
  wire       cfg_wr = sfr_write && (sfr_addr == 8'h8E);
  wire       ctl_wr = sfr_write && (sfr_addr == 8'h88);
  wire       rd_ok  = !sfr_write;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

////////////////////////////////////////////////////////////////////////
  AST_CFG_WR: assert property (cfg_wr |=> ck_hi == $past(sfr_wdata[7:4]))
    else $error("clock select outputs miss a config write");
  AST_CFG_HOLD: assert property (!cfg_wr |=> $stable(ck_hi))
    else $error("clock select outputs moved without a config write");
  AST_CFG_RD: assert property (sfr_addr == 8'h8E && rd_ok |=> sfr_rdata[7:4] == $past(ck_hi))
    else $error("config readback differs from select outputs");
  AST_IRQ0_EN: assert property (!timer0_irq_enable |-> !timer0_irq)
    else $error("timer 0 request while disabled");
  AST_IRQ1_EN: assert property (!timer1_irq_enable |-> !timer1_irq)
    else $error("timer 1 request while disabled");
  AST_FLAG0_HOLD: assert property (timer0_irq && !timer0_vector_ack && !ctl_wr ##1 timer0_irq_enable |-> timer0_irq)
    else $error("timer 0 flag dropped without a clear");
  AST_FLAG1_HOLD: assert property (timer1_irq && !timer1_vector_ack && !ctl_wr ##1 timer1_irq_enable |-> timer1_irq)
    else $error("timer 1 flag dropped without a clear");
  AST_RD_FLAG0: assert property (sfr_addr == 8'h88 && rd_ok && timer0_irq_enable |=> sfr_rdata[5] == $past(timer0_irq))
    else $error("timer 0 flag readback wrong");
  AST_RD_FLAG1: assert property (sfr_addr == 8'h88 && rd_ok && timer1_irq_enable |=> sfr_rdata[7] == $past(timer1_irq))
    else $error("timer 1 flag readback wrong");
endmodule // dtc_timer01_props

bind dtc_timer01 dtc_timer01_props dtc_timer01_props_i (
  .clk, .rstn, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata,
  .timer0_irq_enable, .timer1_irq_enable, .timer0_vector_ack, .timer1_vector_ack,
  .timer0_irq, .timer1_irq, .timer3_high_clock_choice, .timer3_low_clock_choice,
  .timer2_high_clock_choice, .timer2_low_clock_choice
);

// [test/dtc_timer01_tb.sv]
/*
  self-checking bench for the dual timer block: reset values, a table of
  counting cases, then pin counting, split mode and flag acknowledge.
  assumes the pin model drives count pins and the external clock.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module dtc_timer01_tb;
  typedef struct packed {
    logic       t;
    logic [7:0] md, ck, ctl, lo, hi, n, elo, ehi;
    logic       ef;
  } dtc_row_t;
  reg        clk, rstn, sfr_write, start, sel, ext_gate_input_zero, ext_gate_input_one;
  reg        gate_zero_polarity, gate_one_polarity;
  reg        timer0_irq_enable, timer1_irq_enable, timer0_vector_ack, timer1_vector_ack;
  reg  [7:0] sfr_addr, sfr_wdata, edges, v, m;
  wire [7:0] sfr_rdata;
  wire       timer_zero_count_pin, timer_one_count_pin, ext_clock, busy, timer0_irq;
  wire       timer1_irq, timer1_overflow_pulse, timer3_high_clock_choice;
  wire       timer3_low_clock_choice, timer2_high_clock_choice, timer2_low_clock_choice;
  integer    mismatches = 0, comparisons = 0, cyc = 0, n0 = 0, n1 = 0, np = 0, i, k, j;
  dtc_row_t  rows [0:11];

  dtc_timer01 dtc_timer01_i (.clk, .rstn, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata,
    .timer_zero_count_pin, .timer_one_count_pin, .ext_gate_input_zero,
    .ext_gate_input_one, .gate_zero_polarity, .gate_one_polarity, .ext_clock,
    .timer0_irq_enable, .timer1_irq_enable, .timer0_vector_ack, .timer1_vector_ack,
    .timer0_irq, .timer1_irq, .timer1_overflow_pulse, .timer3_high_clock_choice,
    .timer3_low_clock_choice, .timer2_high_clock_choice, .timer2_low_clock_choice);
  dtc_pin_model dtc_pin_model_i (.clk(clk), .start(start), .sel(sel), .edges(edges),
    .pin0(timer_zero_count_pin), .pin1(timer_one_count_pin), .ext_clock(ext_clock),
    .busy(busy));

////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge clk);
    sfr_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [7:0] a, output [7:0] d);
    sfr_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = sfr_rdata;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // flags seen through the requests; counted so the main flow only reads
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timer0_irq) n0 <= n0 + 1;
    if (timer1_irq) n1 <= n1 + 1;
    if (timer1_overflow_pulse) np <= np + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude;
    end
  end

////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{1'b0, 8'h00, 8'h04, 8'h10, 8'h1E, 8'hFF, 8'h03, 8'h01, 8'h00, 1'b1},
      '{1'b0, 8'h01, 8'h04, 8'h10, 8'hFE, 8'hFF, 8'h03, 8'h01, 8'h00, 1'b1},
      '{1'b0, 8'h02, 8'h04, 8'h10, 8'hFE, 8'hF0, 8'h04, 8'hF2, 8'hF0, 1'b1},
      '{1'b0, 8'h01, 8'h04, 8'h10, 8'h34, 8'h12, 8'h05, 8'h39, 8'h12, 1'b0},
      '{1'b0, 8'h01, 8'h00, 8'h10, 8'h00, 8'h00, 8'h18, 8'h02, 8'h00, 1'b0},
      '{1'b0, 8'h01, 8'h01, 8'h10, 8'h00, 8'h00, 8'h08, 8'h02, 8'h00, 1'b0},
      '{1'b0, 8'h01, 8'h02, 8'h10, 8'h00, 8'h00, 8'h30, 8'h01, 8'h00, 1'b0},
      '{1'b0, 8'h01, 8'h03, 8'h10, 8'h00, 8'h00, 8'h40, 8'h02, 8'h00, 1'b0},
      '{1'b0, 8'h09, 8'h04, 8'h10, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 1'b0},
      '{1'b1, 8'h10, 8'h08, 8'h40, 8'hFE, 8'hFF, 8'h03, 8'h01, 8'h00, 1'b1},
      '{1'b1, 8'h30, 8'h08, 8'h40, 8'h05, 8'h00, 8'h06, 8'h05, 8'h00, 1'b0},
      '{1'b1, 8'h10, 8'h01, 8'h40, 8'h00, 8'h00, 8'h08, 8'h02, 8'h00, 1'b0}};
    {rstn, sfr_write, start, sel, ext_gate_input_zero, ext_gate_input_one} = 6'h00;
    {timer0_vector_ack, timer1_vector_ack} = 2'b00;
    {timer0_irq_enable, timer1_irq_enable} = 2'b11;
    {gate_zero_polarity, gate_one_polarity} = 2'b11;
    {sfr_addr, sfr_wdata, edges} = 24'h000000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rd(8'h88 + i[7:0], v);
      `CHK(v, 8'h00)
    end
    wr(8'h8E, 8'hF0);
    rd(8'h8E, v);
    `CHK(v, 8'hF0)
    `CHK({timer3_high_clock_choice, timer3_low_clock_choice}, 2'b11)
    `CHK({timer2_high_clock_choice, timer2_low_clock_choice}, 2'b11)
    for (i = 0; i < 12; i++) begin
      wr(8'h89, rows[i].md);
      wr(8'h8E, rows[i].ck);
      wr(rows[i].t ? 8'h8B : 8'h8A, rows[i].lo);
      wr(rows[i].t ? 8'h8D : 8'h8C, rows[i].hi);
      k = rows[i].t ? n1 : n0;
      wr(8'h88, rows[i].ctl);
      repeat (rows[i].n - 2) @(posedge clk);
      wr(8'h88, 8'h00);
      m = ((rows[i].t ? rows[i].md[5:4] : rows[i].md[1:0]) == 2'b00) ? 8'h1F : 8'hFF;
      rd(rows[i].t ? 8'h8B : 8'h8A, v);
      `CHK(v & m, rows[i].elo)
      rd(rows[i].t ? 8'h8D : 8'h8C, v);
      `CHK(v, rows[i].ehi)
      `CHK((rows[i].t ? n1 : n0) != k, rows[i].ef)
    end
    wr(8'h8E, 8'h0C);
    for (i = 0; i < 2; i++) begin
      wr(8'h89, i ? 8'h50 : 8'h05);
      wr(i ? 8'h8B : 8'h8A, 8'h00);
      wr(8'h88, i ? 8'h40 : 8'h10);
      sel   <= i[0];
      edges <= 8'h03 + i[7:0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 300 && busy; k++) @(posedge clk);
      repeat (4) @(posedge clk);
      wr(8'h88, 8'h00);
      rd(i ? 8'h8B : 8'h8A, v);
      `CHK(v, 8'h03 + i[7:0])
    end
    // gate inputs low but active-low polarity: both timers must count
    {gate_zero_polarity, gate_one_polarity} <= 2'b00;
    for (i = 0; i < 2; i++) begin
      wr(8'h89, i ? 8'h90 : 8'h09);
      wr(i ? 8'h8B : 8'h8A, 8'h00);
      wr(8'h88, i ? 8'h40 : 8'h10);
      wr(8'h88, 8'h00);
      rd(i ? 8'h8B : 8'h8A, v);
      `CHK(v, 8'h02)
    end
    wr(8'h89, 8'h23);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h8B, 8'hFF);
    k = np;
    j = n1;
    repeat (5) @(posedge clk);
    `CHK(np > k, 1'b1)
    `CHK(n1, j)
    wr(8'h88, 8'h40);
    repeat (4) @(posedge clk);
    rd(8'h88, v);
    `CHK(v, 8'hC0)
    rd(8'h8A, v);
    `CHK(v, 8'hFE)
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h01);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    repeat (3) @(posedge clk);
    rd(8'h88, v);
    `CHK(v, 8'h30)
    timer0_vector_ack <= 1'b1;
    @(posedge clk);
    timer0_vector_ack <= 1'b0;
    @(negedge clk);
    `CHK(timer0_irq, 1'b0)
    conclude;
  end
endmodule // dtc_timer01_tb

// [verilog/dtc_defs.vh]
/*
  constants for the dual timer/counter block: register offsets, field
  positions, mode codes, prescale codes and divider counts.
  assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// special function register offsets
`define DTC_ADDR_CONTROL   8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_T0_LOW    8'h8A
`define DTC_ADDR_T1_LOW    8'h8B
`define DTC_ADDR_T0_HIGH   8'h8C
`define DTC_ADDR_T1_HIGH   8'h8D
`define DTC_ADDR_CLK_CFG   8'h8E

`define DTC_RESET_BYTE     8'h00

// clock config fields
`define DTC_CK_T3H         7
`define DTC_CK_T3L         6
`define DTC_CK_T2H         5
`define DTC_CK_T2L         4
`define DTC_CK_T1          3
`define DTC_CK_T0          2
`define DTC_CK_DIV_HI      1
`define DTC_CK_DIV_LO      0

// control register fields (timer bits only are stored here)
`define DTC_CT_TF1         7
`define DTC_CT_TR1         6
`define DTC_CT_TF0         5
`define DTC_CT_TR0         4

// mode register fields
`define DTC_MD_TIMER1_GATE_ENABLE       7
`define DTC_MD_CSEL1       6
`define DTC_MD_M1_HI       5
`define DTC_MD_M1_LO       4
`define DTC_MD_TIMER0_GATE_ENABLE       3
`define DTC_MD_CSEL0       2
`define DTC_MD_M0_HI       1
`define DTC_MD_M0_LO       0

// timer modes
`define DTC_MODE_13BIT     2'b00
`define DTC_MODE_16BIT     2'b01
`define DTC_MODE_RELOAD    2'b10
`define DTC_MODE_SPLIT     2'b11

// prescale choices
`define DTC_DIV_BY12       2'b00
`define DTC_DIV_BY4        2'b01
`define DTC_DIV_BY48       2'b10
`define DTC_DIV_EXT8       2'b11

// terminal counts (divisor minus one)
`define DTC_CNT_BY12       6'h0B
`define DTC_CNT_BY4        6'h03
`define DTC_CNT_BY48       6'h2F
`define DTC_CNT_EXT8       6'h07

`define DTC_LOW5_MAX       5'h1F
`define DTC_BYTE_MAX       8'hFF
`define DTC_WORD_MAX       16'hFFFF

`endif

// [verilog/dtc_prescaler.v]
/*
  timer 0/1 prescaler: one-cycle tick at system clock /12, /4, /48, or
  external clock /8. assumes the external clock input is a raw pin level;
  it is synchronised here and its rising edges are counted.
*/
`timescale 1ns/1ns
`include "dtc_defs.vh"

module dtc_prescaler (
  input  wire       clk,
  input  wire       rstn,
  input  wire [1:0] clock_divider_choice,
  input  wire       ext_clock,
  output reg        tick
);

  reg  [5:0] count;
  reg  [5:0] limit;
  reg        ext_meta;
  reg        ext_sync;
  reg        ext_prev;
  wire       ext_mode;
  wire       step;

  assign ext_mode = (clock_divider_choice == `DTC_DIV_EXT8);
  // external mode advances only on synchronised rising edges
  assign step = ext_mode ? (ext_sync & ~ext_prev) : 1'b1;

  always @* begin
    case (clock_divider_choice)
      `DTC_DIV_BY12: limit = `DTC_CNT_BY12;
      `DTC_DIV_BY4:  limit = `DTC_CNT_BY4;
      `DTC_DIV_BY48: limit = `DTC_CNT_BY48;
      default:       limit = `DTC_CNT_EXT8;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      count    <= 6'h00;
      tick     <= 1'b0;
    end else begin
      ext_meta <= ext_clock;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      tick     <= 1'b0;
      if (step) begin
        // >= guards against a choice change leaving count past limit
        if (count >= limit) begin // [R1]
          count <= 6'h00;
          tick  <= 1'b1;
        end else begin
          count <= count + 6'h01;
        end
      end
    end
  end

endmodule // dtc_prescaler

// [verilog/dtc_timer01.v]
/*
  two 8051-style counter/timers plus the shared clock configuration
  register. registers are reached on a simple special-function bus
  (address, write strobe, data in, read data out).
  assumes count and gate pins are synchronous level inputs; the
  interrupt controller supplies vector acknowledge pulses.
*/
`timescale 1ns/1ns
`include "dtc_defs.vh"

////////////////////////////////////////////////////////////////////////
// Function
// [R1] prescale choice gives tick at clk/12, /4, /48, or external clock/8
// [R2] clock config bit 3 picks timer 1 clock, ignored in counter mode
// [R3] clock config bit 2 picks timer 0 clock, ignored in counter mode
// [R4] bits 7 and 6 drive timer 3 high and low clock selects
// [R5] bits 5 and 4 drive timer 2 high and low clock selects
// [R6] 13-bit mode: high byte upper eight bits, low bits 4..0 lower five
// [R7] 13-bit wrap 1FFF to 0 sets overflow flag, interrupt if enabled
// [R8] count-select 1 counts pin falling edges, else configured clock
// [R9] count when run bit set and gate off or gate input active
// [R10] setting run bit leaves count alone; software preloads it
// [R11] timer 1 mirrors timer 0 with its own bits and gate input one
// [R12] 16-bit mode counts full word, same enable and clocking
// [R13] reload mode: low byte wraps, flag set, reloaded from high byte
// [R14] software preloads low byte before enabling reload mode
// [R15] split mode: timer 0 low byte is full counter/timer on timer 0 bits
// [R16] split high byte: timer only, timer 1 run bit and flag
// [R17] timer 1 mode 3 holds its count
// [R18] timer 0 split: timer 1 no pin counting, no flag, pulse still out
// [R19] timer 0 split: timer 1 runs by mode field alone
// [R20] mode field 00 13-bit, 01 16-bit, 10 reload, 11 split or off
// [R21] overflow flags cleared by software or on interrupt vectoring
// [R22] count pin levels must hold two system clock cycles
// [R23] pins sampled on clk; falling edges give one increment per cycle
module dtc_timer01 (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_write,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire       timer_zero_count_pin,
  input  wire       timer_one_count_pin,
  input  wire       ext_gate_input_zero,
  input  wire       ext_gate_input_one,
  input  wire       gate_zero_polarity,
  input  wire       gate_one_polarity,
  input  wire       ext_clock,
  input  wire       timer0_irq_enable,
  input  wire       timer1_irq_enable,
  input  wire       timer0_vector_ack,
  input  wire       timer1_vector_ack,
  output wire       timer0_irq,
  output wire       timer1_irq,
  output reg        timer1_overflow_pulse,
  output wire       timer3_high_clock_choice,
  output wire       timer3_low_clock_choice,
  output wire       timer2_high_clock_choice,
  output wire       timer2_low_clock_choice
);

  reg  [7:0] timer_clock_config;
  reg  [7:0] timer_mode_reg;
  reg        timer0_run_bit;
  reg        timer1_run_bit;
  reg        timer0_overflow_flag;
  reg        timer1_overflow_flag;
  reg  [7:0] timer0_low_byte;
  reg  [7:0] timer0_high_byte;
  reg  [7:0] timer1_low_byte;
  reg  [7:0] timer1_high_byte;
  wire [1:0] gate_sync;
  wire       presc_tick;
  wire [1:0] pin_fall;

  ////////////////////////////////////////////////////////////////////
  // prescaler

  dtc_prescaler u_presc (
    .clk                  (clk),
    .rstn                 (rstn),
    .clock_divider_choice (timer_clock_config[`DTC_CK_DIV_HI:`DTC_CK_DIV_LO]),
    .ext_clock            (ext_clock),
    .tick                 (presc_tick)
  );

  assign timer3_high_clock_choice = timer_clock_config[`DTC_CK_T3H]; // [R4]
  assign timer3_low_clock_choice  = timer_clock_config[`DTC_CK_T3L]; // [R4]
  assign timer2_high_clock_choice = timer_clock_config[`DTC_CK_T2H]; // [R5]
  assign timer2_low_clock_choice  = timer_clock_config[`DTC_CK_T2L]; // [R5]

  ////////////////////////////////////////////////////////////////////
  // pin sampling; pins are synchronous so one register stage suffices

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pins
      wire pin_in;
      wire gate_in;
      // per-pin stages live here so each flop has a single driving process
      reg  pin_sync;
      reg  pin_prev;
      reg  gate_seen;
      assign pin_in  = (gi == 0) ? timer_zero_count_pin : timer_one_count_pin;
      assign gate_in = (gi == 0) ? (ext_gate_input_zero ~^ gate_zero_polarity)
                                 : (ext_gate_input_one ~^ gate_one_polarity);
      always @(posedge clk) begin
        if (!rstn) begin
          // idle-high reset level, so no false edge after reset
          pin_sync  <= 1'b1;
          pin_prev  <= 1'b1;
          gate_seen <= 1'b0;
        end else begin
          pin_sync  <= pin_in; // [R23]
          pin_prev  <= pin_sync;
          gate_seen <= gate_in;
        end
      end
      // at most one edge per cycle, so at most one increment [R23]
      assign pin_fall[gi]  = pin_prev & ~pin_sync; // [R8]
      assign gate_sync[gi] = gate_seen; // [R9]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // count enables

  // one clock source choice: pin edge, system clock, or prescaled tick
  function clock_step;
    input count_sel;
    input sys_sel;
    input pin_edge;
    input tick;
    begin
      if (count_sel)
        clock_step = pin_edge;          // [R8]
      else
        clock_step = sys_sel | tick;    // [R2] [R3]
    end
  endfunction

  // run and gate qualification
  function run_ok;
    input run;
    input gate_en;
    input gate_active;
    begin
      run_ok = run & (~gate_en | gate_active); // [R9]
    end
  endfunction

  wire [1:0] mode0 = timer_mode_reg[`DTC_MD_M0_HI:`DTC_MD_M0_LO];
  wire [1:0] mode1 = timer_mode_reg[`DTC_MD_M1_HI:`DTC_MD_M1_LO];
  wire       split = (mode0 == `DTC_MODE_SPLIT); // [R20]

  wire t0_step = run_ok(timer0_run_bit, timer_mode_reg[`DTC_MD_TIMER0_GATE_ENABLE], gate_sync[0]) &
                 clock_step(timer_mode_reg[`DTC_MD_CSEL0],
                            timer_clock_config[`DTC_CK_T0], pin_fall[0], presc_tick);
  // split high byte: timer only, run by timer 1 run bit [R16]
  wire th0_step = timer1_run_bit &
                  clock_step(1'b0, timer_clock_config[`DTC_CK_T0], 1'b0, presc_tick);
  // with timer 0 split, timer 1 runs by mode alone and never from its pin [R18] [R19]
  wire t1_step_n = run_ok(timer1_run_bit, timer_mode_reg[`DTC_MD_TIMER1_GATE_ENABLE], gate_sync[1]) &
                   clock_step(timer_mode_reg[`DTC_MD_CSEL1],
                              timer_clock_config[`DTC_CK_T1], pin_fall[1], presc_tick);
  wire t1_step_s = clock_step(1'b0, timer_clock_config[`DTC_CK_T1], 1'b0, presc_tick);
  wire t1_step   = (mode1 != `DTC_MODE_SPLIT) & (split ? t1_step_s : t1_step_n); // [R17]

  ////////////////////////////////////////////////////////////////////
  // shared counting function per mode: returns {wrap, high, low}

  function [16:0] advance;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg   [15:0] word;
    begin
      word = 16'h0000;
      case (mode)
        `DTC_MODE_13BIT: begin // [R6]
          // upper low bits kept as-is; software masks them
          if (lo[4:0] == `DTC_LOW5_MAX)
            advance = {(hi == `DTC_BYTE_MAX), hi + 8'h01, lo[7:5], 5'h00}; // [R7]
          else
            advance = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
        `DTC_MODE_16BIT: begin // [R12]
          word    = {hi, lo} + 16'h0001;
          advance = {({hi, lo} == `DTC_WORD_MAX), word};
        end
        `DTC_MODE_RELOAD: begin // [R13]
          if (lo == `DTC_BYTE_MAX)
            advance = {1'b1, hi, hi};
          else
            advance = {1'b0, hi, lo + 8'h01};
        end
        default: begin // split low byte: plain 8-bit [R15]
          advance = {(lo == `DTC_BYTE_MAX), hi, lo + 8'h01};
        end
      endcase
    end
  endfunction

  wire [16:0] t0_next  = advance(mode0, timer0_low_byte, timer0_high_byte);
  wire [16:0] t1_next  = advance(mode1, timer1_low_byte, timer1_high_byte);
  wire        t0_wrap  = t0_step & t0_next[16];
  wire        th0_wrap = split & th0_step & (timer0_high_byte == `DTC_BYTE_MAX);
  wire        t1_wrap  = t1_step & t1_next[16];

  function is_addr;
    input [7:0] addr;
    input [7:0] want;
    begin
      is_addr = sfr_write & (addr == want);
    end
  endfunction

  wire wr_ctl = is_addr(sfr_addr, `DTC_ADDR_CONTROL);

  ////////////////////////////////////////////////////////////////////
  // configuration, mode and run bits

  always @(posedge clk) begin
    if (!rstn) begin
      timer_clock_config <= `DTC_RESET_BYTE;
      timer_mode_reg     <= `DTC_RESET_BYTE;
      timer0_run_bit     <= 1'b0;
      timer1_run_bit     <= 1'b0;
    end else begin
      if (is_addr(sfr_addr, `DTC_ADDR_CLK_CFG))
        timer_clock_config <= sfr_wdata;
      if (is_addr(sfr_addr, `DTC_ADDR_MODE))
        timer_mode_reg <= sfr_wdata;
      if (wr_ctl) begin
        // run bits only gate counting; counts untouched [R10]
        timer0_run_bit <= sfr_wdata[`DTC_CT_TR0];
        timer1_run_bit <= sfr_wdata[`DTC_CT_TR1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer 0 word; software write beats a same-cycle count

  always @(posedge clk) begin
    if (!rstn) begin
      timer0_low_byte  <= `DTC_RESET_BYTE;
      timer0_high_byte <= `DTC_RESET_BYTE;
    end else begin
      if (t0_step) begin
        timer0_low_byte <= t0_next[7:0];
        if (!split)
          timer0_high_byte <= t0_next[15:8];
      end
      // split high byte has its own step, so the two halves never race
      if (split && th0_step)
        timer0_high_byte <= timer0_high_byte + 8'h01; // [R16]
      if (is_addr(sfr_addr, `DTC_ADDR_T0_LOW))
        timer0_low_byte <= sfr_wdata;
      if (is_addr(sfr_addr, `DTC_ADDR_T0_HIGH))
        timer0_high_byte <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer 1 word and its overflow pulse [R11]

  always @(posedge clk) begin
    if (!rstn) begin
      timer1_low_byte       <= `DTC_RESET_BYTE;
      timer1_high_byte      <= `DTC_RESET_BYTE;
      timer1_overflow_pulse <= 1'b0;
    end else begin
      if (t1_step) begin
        timer1_low_byte  <= t1_next[7:0];
        timer1_high_byte <= t1_next[15:8];
      end
      if (is_addr(sfr_addr, `DTC_ADDR_T1_LOW))
        timer1_low_byte <= sfr_wdata;
      if (is_addr(sfr_addr, `DTC_ADDR_T1_HIGH))
        timer1_high_byte <= sfr_wdata;
      // overflow to baud and converter logic, even when split [R18]
      timer1_overflow_pulse <= t1_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over software or vector clear [R21]

  always @(posedge clk) begin
    if (!rstn) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      if (t0_wrap) // [R7] [R13] [R15]
        timer0_overflow_flag <= 1'b1;
      else if (timer0_vector_ack)
        timer0_overflow_flag <= 1'b0;
      else if (wr_ctl)
        timer0_overflow_flag <= sfr_wdata[`DTC_CT_TF0];

      // a split timer 1 wrap only pulses; only the timer 0 high byte raises the flag
      if (th0_wrap || (t1_wrap && !split)) // [R16] [R18]
        timer1_overflow_flag <= 1'b1;
      else if (timer1_vector_ack)
        timer1_overflow_flag <= 1'b0;
      else if (wr_ctl)
        timer1_overflow_flag <= sfr_wdata[`DTC_CT_TF1];
    end
  end

  assign timer0_irq = timer0_overflow_flag & timer0_irq_enable; // [R7]
  assign timer1_irq = timer1_overflow_flag & timer1_irq_enable;

  ////////////////////////////////////////////////////////////////////
  // read data, registered; unmapped addresses read zero

  always @(posedge clk) begin
    if (!rstn) begin
      sfr_rdata <= `DTC_RESET_BYTE;
    end else begin
      case (sfr_addr)
        `DTC_ADDR_CONTROL: sfr_rdata <= {timer1_overflow_flag, timer1_run_bit,
                                         timer0_overflow_flag, timer0_run_bit, 4'h0};
        `DTC_ADDR_MODE:    sfr_rdata <= timer_mode_reg;
        `DTC_ADDR_T0_LOW:  sfr_rdata <= timer0_low_byte;
        `DTC_ADDR_T1_LOW:  sfr_rdata <= timer1_low_byte;
        `DTC_ADDR_T0_HIGH: sfr_rdata <= timer0_high_byte;
        `DTC_ADDR_T1_HIGH: sfr_rdata <= timer1_high_byte;
        `DTC_ADDR_CLK_CFG: sfr_rdata <= timer_clock_config;
        default:           sfr_rdata <= `DTC_RESET_BYTE;
      endcase
    end
  end

endmodule // dtc_timer01
